/* File: hw/dpgci_pkg.sv */
// Package of constants and carriers for the dual-port GPIO block
package dpgci_pkg;
    // Register bus widths
    localparam int ADDR_W = 9;
    localparam int DATA_W = 8;
    // Second port registers, each but the analog select answering at two mirrored addresses
    localparam logic [8:0] ADDR_SECOND_PORT_A = 9'h006;
    localparam logic [8:0] ADDR_SECOND_PORT_B = 9'h106;
    localparam logic [8:0] ADDR_OPTION_A = 9'h081;
    localparam logic [8:0] ADDR_OPTION_B = 9'h181;
    localparam logic [8:0] ADDR_SECOND_DIR_A = 9'h086;
    localparam logic [8:0] ADDR_SECOND_DIR_B = 9'h186;
    localparam logic [8:0] ADDR_ANALOG_CFG = 9'h09F;
    // Third port registers
    localparam logic [8:0] ADDR_THIRD_PORT = 9'h007;
    localparam logic [8:0] ADDR_THIRD_DIR = 9'h087;
    // Interrupt registers
    localparam logic [8:0] ADDR_IRQ_STATUS = 9'h00B;
    localparam logic [8:0] ADDR_IRQ_CLEAR = 9'h0C0;
    localparam logic [8:0] ADDR_IRQ_ENABLE = 9'h0C1;
    // Reset values
    localparam logic [7:0] RST_OPTION = 8'hFF;
    localparam logic [7:0] RST_DIR = 8'hFF;
    localparam logic [7:0] RST_ANALOG = 8'h00;
    localparam logic [7:0] RST_LATCH = 8'h00;
    localparam logic [7:0] RST_IRQ_EN = 8'h00;
    // Field positions
    localparam int OPT_PULLUP_DIS_N = 7;
    localparam int OPT_EDGE_SEL = 6;
    localparam int IRQ_PORT_CHANGE = 0;
    localparam int IRQ_EXT = 1;
    localparam int EXT_PIN = 0;
    // Analog select: pins below this index are analog unless all-digital code
    localparam int ANALOG_PINS = 6;
    localparam logic [3:0] ANALOG_ALL_DIGITAL = 4'hF;
    localparam logic [7:0] CHANGE_WATCH_MASK = 8'hF0;

    // Pad drive bundle of one port
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] pu;
    } dpgci_pad_t;

    // Peripheral override bundle of one port
    typedef struct packed {
        logic [7:0] sel;
        logic [7:0] dout;
        logic [7:0] oe;
        logic [7:0] ovr;
        logic [7:0] ovr_in;
    } dpgci_periph_t;
endpackage

/* File: hw/dpgci_top.sv */
// Dual-port GPIO with pull-ups, analog select and change interrupt
`timescale 1ns/10ps
// Summary of operation
// - Second port: direction 1 releases the pin, 0 drives the output latch.
// - Third port follows the same direction behaviour as the second port.
// - Option bit 7 cleared turns on weak pull-ups of second-port input pins.
// - A second-port pin acting as output never has its pull-up on.
// - After reset pull-ups are off, the global pull-up bit reads one.
// - Second-port pins 0 to 5 can be analog; after reset analog, reading zero.
// - Only upper four second-port pins set as inputs join the change compare.
// - Watched inputs are compared against the snapshot taken at last access.
// - Mismatches of the watched pins are ORed into the port change flag, bit 0.
// - A port change event raises a wake request while the core sleeps.
// - Any read or write of the second port refreshes the snapshot.
// - While a mismatch stays, the port change flag keeps being set.
// - Second-port pin 0 is an external interrupt, edge chosen by option bit 6.
// - An enabled peripheral may force a pin direction on either port.
// - Third port select picks peripheral data; peripheral enable acts only then.
module dpgci_top
    import dpgci_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Register port
    input wire logic [dpgci_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [dpgci_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [dpgci_pkg::DATA_W-1:0] reg_rdata,
    // Second port pads
    input wire logic [7:0] second_pin_in,
    output dpgci_pkg::dpgci_pad_t second_pad,
    // Third port pads
    input wire logic [7:0] third_pin_in,
    output dpgci_pkg::dpgci_pad_t third_pad,
    // Peripheral overrides
    input wire dpgci_pkg::dpgci_periph_t second_periph,
    input wire dpgci_pkg::dpgci_periph_t third_periph,
    // Sleep, wake and interrupt
    input wire logic sleep_active,
    output logic wake_req,
    output logic irq
);
    import dpgci_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Effective input mask: override wins over the direction register
    function automatic logic [7:0] eff_input(
        input logic [7:0] dir,
        input logic [7:0] ovr,
        input logic [7:0] ovr_in
    );
        eff_input = (ovr & ovr_in) | (~ovr & dir);
    endfunction

    // Address match for a register with two mirrored addresses
    function automatic logic hit2(
        input logic [8:0] a,
        input logic [8:0] m0,
        input logic [8:0] m1
    );
        hit2 = (a == m0) || (a == m1);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [7:0] second_latch_q;
    logic [7:0] second_dir_q;
    logic [7:0] option_q;
    logic [7:0] analog_cfg_q;
    logic [7:0] third_latch_q;
    logic [7:0] third_dir_q;
    logic [7:0] irq_status_q;
    logic [7:0] irq_status_d;
    logic [7:0] irq_en_q;
    logic [7:0] second_meta_q;
    logic [7:0] second_sync_q;
    logic [7:0] third_meta_q;
    logic [7:0] third_sync_q;
    logic [7:0] snapshot_q;
    logic ext_prev_q;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    dpgci_pad_t second_pad_q;
    dpgci_pad_t second_pad_d;
    dpgci_pad_t third_pad_q;
    dpgci_pad_t third_pad_d;
    logic irq_q;
    logic wake_q;
    logic [7:0] analog_mask;
    logic [7:0] second_in_mask;
    logic [7:0] third_in_mask;
    logic [7:0] second_read;
    logic [7:0] mismatch;
    logic change_evt;
    logic ext_evt;
    logic sel_second;
    logic wr_second;
    logic wr_clear;

    ////////////////////////////////////////////////////////////////////////
    // Address decode

    assign sel_second = hit2(reg_addr, ADDR_SECOND_PORT_A, ADDR_SECOND_PORT_B);
    assign wr_second = reg_wr && sel_second;
    assign wr_clear = reg_wr && (reg_addr == ADDR_IRQ_CLEAR);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    // Two flops per pin; only the second stage feeds logic
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            second_meta_q <= 8'h00;
            second_sync_q <= 8'h00;
            third_meta_q <= 8'h00;
            third_sync_q <= 8'h00;
        end else begin
            second_meta_q <= second_pin_in;
            second_sync_q <= second_meta_q;
            third_meta_q <= third_pin_in;
            third_sync_q <= third_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers

    // Direction, option and analog registers; mirrors behave alike
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            second_dir_q <= RST_DIR;
            third_dir_q <= RST_DIR;
            option_q <= RST_OPTION;
            analog_cfg_q <= RST_ANALOG;
            irq_en_q <= RST_IRQ_EN;
        end else if (reg_wr) begin
            if (hit2(reg_addr, ADDR_SECOND_DIR_A, ADDR_SECOND_DIR_B)) begin
                second_dir_q <= reg_wdata;
            end
            if (hit2(reg_addr, ADDR_OPTION_A, ADDR_OPTION_B)) begin
                option_q <= reg_wdata;
            end
            if (reg_addr == ADDR_THIRD_DIR) begin
                third_dir_q <= reg_wdata;
            end
            if (reg_addr == ADDR_ANALOG_CFG) begin
                analog_cfg_q <= reg_wdata;
            end
            if (reg_addr == ADDR_IRQ_ENABLE) begin
                irq_en_q <= reg_wdata;
            end
        end
    end

    // Port writes load the output latches; a second-port write also refreshes the snapshot
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            second_latch_q <= RST_LATCH;
            third_latch_q <= RST_LATCH;
        end else if (reg_wr) begin
            if (sel_second) begin
                second_latch_q <= reg_wdata;
            end
            if (reg_addr == ADDR_THIRD_PORT) begin
                third_latch_q <= reg_wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Direction, analog and pad drive

    // Lower pins turn analog unless the all-digital code is set
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            analog_mask[i] = (i < ANALOG_PINS) &&
                (analog_cfg_q[3:0] != ANALOG_ALL_DIGITAL);
        end
    end

    // Peripheral override forces direction on either port
    assign second_in_mask = eff_input(second_dir_q, second_periph.ovr,
        second_periph.ovr_in);
    assign third_in_mask = eff_input(third_dir_q, third_periph.ovr,
        third_periph.ovr_in);

    // Second port: pull-ups only on input pins with the global bit low
    always_comb begin
        second_pad_d.out = second_latch_q;
        second_pad_d.oe = ~second_in_mask;
        second_pad_d.pu = option_q[OPT_PULLUP_DIS_N] ? 8'h00 :
            second_in_mask;
    end

    // Third port: peripheral data and enable count only when selected
    always_comb begin
        third_pad_d.pu = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if (third_periph.sel[i]) begin
                third_pad_d.out[i] = third_periph.dout[i];
                third_pad_d.oe[i] = third_periph.oe[i];
            end else begin
                third_pad_d.out[i] = third_latch_q[i];
                third_pad_d.oe[i] = ~third_in_mask[i];
            end
        end
    end

    // Pad outputs registered so every top output comes from a flop
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            second_pad_q <= '0;
            third_pad_q <= '0;
        end else begin
            second_pad_q <= second_pad_d;
            third_pad_q <= third_pad_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Change detection

    // Analog pins read as zero
    assign second_read = second_sync_q & ~analog_mask;

    // Snapshot refreshed by any access; polling can hide key presses
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            snapshot_q <= 8'h00;
        end else if ((reg_rd && sel_second) || wr_second) begin
            snapshot_q <= second_read;
        end
    end

    // Watched inputs only; outputs drop out of the comparison
    assign mismatch = (second_read ^ snapshot_q) & second_in_mask &
        CHANGE_WATCH_MASK;
    assign change_evt = |mismatch;

    // External interrupt edge, one selects rising
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ext_prev_q <= 1'b0;
        end else begin
            ext_prev_q <= second_sync_q[EXT_PIN];
        end
    end
    assign ext_evt = option_q[OPT_EDGE_SEL] ?
        (second_sync_q[EXT_PIN] && !ext_prev_q) :
        (!second_sync_q[EXT_PIN] && ext_prev_q);

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status

    // Set wins over clear, so a lasting mismatch re-sets the flag
    always_comb begin
        irq_status_d = irq_status_q;
        if (wr_clear) begin
            irq_status_d = irq_status_q & ~reg_wdata;
        end
        if (change_evt) begin
            irq_status_d[IRQ_PORT_CHANGE] = 1'b1;
        end
        if (ext_evt) begin
            irq_status_d[IRQ_EXT] = 1'b1;
        end
    end

    // Status, interrupt line and wake request
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            irq_status_q <= 8'h00;
            irq_q <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            irq_status_q <= irq_status_d;
            irq_q <= |(irq_status_d & irq_en_q);
            wake_q <= sleep_active && irq_status_d[IRQ_PORT_CHANGE];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path

    // Read data stand one cycle after the strobe; unmapped reads zero
    always_comb begin
        rdata_d = 8'h00;
        if (sel_second) begin
            rdata_d = second_read;
        end else if (hit2(reg_addr, ADDR_SECOND_DIR_A, ADDR_SECOND_DIR_B)) begin
            rdata_d = second_dir_q;
        end else if (hit2(reg_addr, ADDR_OPTION_A, ADDR_OPTION_B)) begin
            rdata_d = option_q;
        end else if (reg_addr == ADDR_ANALOG_CFG) begin
            rdata_d = analog_cfg_q;
        end else if (reg_addr == ADDR_THIRD_PORT) begin
            rdata_d = third_sync_q;
        end else if (reg_addr == ADDR_THIRD_DIR) begin
            rdata_d = third_dir_q;
        end else if (reg_addr == ADDR_IRQ_STATUS) begin
            rdata_d = irq_status_q;
        end else if (reg_addr == ADDR_IRQ_ENABLE) begin
            rdata_d = irq_en_q;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= 8'h00;
        end else if (reg_rd) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign reg_rdata = rdata_q;
    assign second_pad = second_pad_q;
    assign third_pad = third_pad_q;
    assign irq = irq_q;
    assign wake_req = wake_q;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    AST_DIR_SECOND: assert property (
        second_pad.oe == ~$past(second_in_mask))
        else $error("second port enable does not follow direction");

    AST_THIRD_LATCH: assert property (
        $past(third_periph.sel) == 8'h00 |->
        third_pad.oe == ~$past(third_in_mask) && third_pad.out == $past(third_latch_q))
        else $error("third port drive wrong");

    AST_PULLUP_OFF_DIS: assert property (
        $past(option_q[OPT_PULLUP_DIS_N]) |-> second_pad.pu == 8'h00)
        else $error("pull-up on while globally disabled");

    AST_PULLUP_OUTPUT: assert property (
        (second_pad.pu & second_pad.oe) == 8'h00)
        else $error("pull-up on a driven pin");

    AST_ANALOG_ZERO: assert property (
        reg_rd && sel_second && analog_cfg_q[3:0] != ANALOG_ALL_DIGITAL
        |=> reg_rdata[5:0] == 6'h00)
        else $error("analog pin read nonzero");

    AST_SNAP_REFRESH: assert property (
        (reg_rd || reg_wr) && sel_second |=> snapshot_q == $past(second_read))
        else $error("snapshot not refreshed");

    AST_FLAG_STICKS: assert property (
        change_evt && wr_clear && reg_wdata[IRQ_PORT_CHANGE]
        |=> irq_status_q[IRQ_PORT_CHANGE])
        else $error("clear beat an active mismatch");

    AST_OUTPUT_EXCLUDED: assert property (
        (mismatch & ~second_in_mask) == 8'h00 && mismatch[3:0] == 4'h0)
        else $error("excluded pin joined compare");

    AST_EXT_EDGE: assert property (
        ext_evt |=> irq_status_q[IRQ_EXT])
        else $error("external edge lost");

    AST_WAKE: assert property (
        sleep_active && change_evt |=> wake_req)
        else $error("no wake on change");

    AST_READ_LATE: assert property (
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside its cycle");

    COV_CHANGE_IRQ: cover property (change_evt ##1 irq);
    COV_CLEAR_AFTER_READ: cover property (
        reg_rd && sel_second ##1 wr_clear ##1 !irq_status_q[IRQ_PORT_CHANGE]);
    COV_WAKE: cover property (sleep_active ##1 wake_req);
    COV_THIRD_PERIPH: cover property (third_periph.sel != 8'h00);
endmodule

/* File: test/dpgci_pin_model.sv */
// Pin-side model of one port: outside drivers, weak pull-ups and floating lines
`timescale 1ns/10ps
module dpgci_pin_model
    import dpgci_pkg::*;
(
    // Clock
    input wire logic clk_sys,
    // Pad side of the block
    input wire dpgci_pkg::dpgci_pad_t pad,
    // Outside drivers set by the bench
    input wire logic [7:0] ext_val,
    input wire logic [7:0] ext_en,
    // Resolved pin levels
    output logic [7:0] pin_lvl
);
    logic [7:0] last_q = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Block drive first, then outside driver, then pull-up; a bare pin drifts
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pad.oe[i])
                pin_lvl[i] = pad.out[i];
            else if (ext_en[i])
                pin_lvl[i] = ext_val[i];
            else if (pad.pu[i])
                pin_lvl[i] = 1'b1;
            else
                pin_lvl[i] = ~last_q[i]; // Floating, never a stale level
        end
    end

    // Last level, so a released line shows its inverse
    always @(posedge clk_sys) begin
        last_q <= pin_lvl;
    end
endmodule

/* File: test/test_dual_port_gpio_change_irq.sv */
// Self-checking bench of the dual-port GPIO block
`timescale 1ns/10ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin \
    $display("CHECK FAILED at %0t: got %0h exp %0h", $time, got, exp); error_cnt++; end end
module test_dual_port_gpio_change_irq;
    import dpgci_pkg::*;
    logic clk_sys, nrst, reg_wr, reg_rd, sleep_active, wake_req, irq;
    logic [8:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, sp_in, tp_in, sp_ext, sp_en, tp_ext, tp_en, d;
    dpgci_pad_t second_pad, third_pad;
    dpgci_periph_t second_periph, third_periph;
    int error_cnt = 0;
    int n_tests = 0;
    int cyc = 0;

    dpgci_top uut (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .second_pin_in(sp_in),
        .second_pad(second_pad), .third_pin_in(tp_in), .third_pad(third_pad),
        .second_periph(second_periph), .third_periph(third_periph),
        .sleep_active(sleep_active), .wake_req(wake_req), .irq(irq));
    dpgci_pin_model sp_pins (.clk_sys(clk_sys), .pad(second_pad), .ext_val(sp_ext),
        .ext_en(sp_en), .pin_lvl(sp_in));
    dpgci_pin_model tp_pins (.clk_sys(clk_sys), .pad(third_pad), .ext_val(tp_ext),
        .ext_en(tp_en), .pin_lvl(tp_in));

    ////////////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            close_out;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus cycles; strobes last one cycle, read data sampled in the next cycle
    task automatic wr(input logic [8:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [8:0] a, output logic [7:0] v);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // Ends any mismatch and clears every status bit
    task automatic quiet;
        rd(ADDR_SECOND_PORT_A, d);
        wr(ADDR_IRQ_CLEAR, 8'hFF);
        wait_cyc(2);
    endtask
    task automatic close_out;
        $display("Compares %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Reset state, mirrors, analog reads and unmapped places
    task automatic t_reset;
        `CHK(second_pad.oe, 8'h00)
        `CHK(second_pad.pu, 8'h00)
        `CHK(third_pad.pu, 8'h00)
        rd(ADDR_OPTION_A, d);
        `CHK(d, 8'hFF)
        rd(ADDR_OPTION_B, d);
        `CHK(d, 8'hFF)
        rd(ADDR_SECOND_DIR_B, d);
        `CHK(d, 8'hFF)
        rd(ADDR_ANALOG_CFG, d);
        `CHK(d, 8'h00)
        rd(ADDR_SECOND_PORT_B, d);
        `CHK(d, sp_ext & 8'hC0)
        rd(9'h1FF, d);
        `CHK(d, 8'h00)
        rd(ADDR_IRQ_CLEAR, d);
        `CHK(d, 8'h00)
        $display("t_reset done");
    endtask

    // Direction, drive and pin reads on both ports
    task automatic t_dir;
        wr(ADDR_ANALOG_CFG, 8'h0F);
        wr(ADDR_SECOND_PORT_B, 8'hA5);
        wr(ADDR_SECOND_DIR_B, 8'h0F);
        sp_en <= 8'h0F;
        wr(ADDR_THIRD_PORT, 8'h3C);
        wr(ADDR_THIRD_DIR, 8'hF0);
        tp_en <= 8'hF0;
        wait_cyc(6);
        `CHK(second_pad.oe, 8'hF0)
        `CHK(second_pad.out & 8'hF0, 8'hA0)
        `CHK(third_pad.oe, 8'h0F)
        `CHK(third_pad.out & 8'h0F, 8'h0C)
        rd(ADDR_SECOND_PORT_A, d);
        `CHK(d, 8'hAA)
        rd(ADDR_THIRD_PORT, d);
        `CHK(d, 8'hCC)
        rd(ADDR_SECOND_DIR_A, d);
        `CHK(d, 8'h0F)
        $display("t_dir done");
    endtask

    // Global pull-up enable, off on outputs
    task automatic t_pullup;
        wr(ADDR_OPTION_B, 8'h7F);
        wait_cyc(3);
        `CHK(second_pad.pu, 8'h0F)
        wr(ADDR_SECOND_DIR_A, 8'hFF);
        sp_en <= 8'h00;
        wait_cyc(6);
        `CHK(second_pad.pu, 8'hFF)
        rd(ADDR_SECOND_PORT_A, d);
        `CHK(d, 8'hFF)
        wr(ADDR_OPTION_A, 8'hFF);
        sp_en <= 8'hFF;
        wait_cyc(6);
        `CHK(second_pad.pu, 8'h00)
        $display("t_pullup done");
    endtask

    // Change compare, sticky flag, refresh by access, mask and wake
    task automatic t_change;
        wr(ADDR_IRQ_ENABLE, 8'h01);
        quiet;
        // Lower pins move but pin 0 holds, so no external edge either
        sp_ext <= sp_ext ^ 8'h0E;
        wait_cyc(6);
        rd(ADDR_IRQ_STATUS, d);
        `CHK(d, 8'h00)
        // Pin 6 turns output and its level changes, yet stays out of the compare
        wr(ADDR_SECOND_DIR_A, 8'hBF);
        sp_en <= 8'hBF;
        wait_cyc(6);
        rd(ADDR_IRQ_STATUS, d);
        `CHK(d, 8'h00)
        // No port polling while waiting for the change
        sleep_active <= 1'b1;
        sp_ext <= sp_ext ^ 8'h80;
        wait_cyc(6);
        `CHK(irq, 1'b1)
        `CHK(wake_req, 1'b1)
        wr(ADDR_IRQ_CLEAR, 8'h01);
        rd(ADDR_IRQ_STATUS, d);
        `CHK(d, 8'h01)
        // Pin 6 shows its latch bit, the rest the outside levels
        rd(ADDR_SECOND_PORT_B, d);
        `CHK(d, 8'h94)
        wr(ADDR_IRQ_CLEAR, 8'h01);
        wait_cyc(2);
        rd(ADDR_IRQ_STATUS, d);
        `CHK(d, 8'h00)
        `CHK(irq, 1'b0)
        sleep_active <= 1'b0;
        sp_ext <= sp_ext ^ 8'h10;
        wait_cyc(6);
        `CHK(wake_req, 1'b0)
        wr(ADDR_SECOND_PORT_A, 8'hA5);
        wr(ADDR_IRQ_CLEAR, 8'h01);
        wait_cyc(2);
        rd(ADDR_IRQ_STATUS, d);
        `CHK(d, 8'h00)
        sp_ext <= sp_ext ^ 8'h20;
        wait_cyc(6);
        `CHK(irq, 1'b1)
        wr(ADDR_IRQ_ENABLE, 8'h00);
        wait_cyc(2);
        `CHK(irq, 1'b0)
        quiet;
        $display("t_change done");
    endtask

    // External pin edge under both edge selections
    task automatic t_ext;
        sp_ext <= sp_ext & 8'hFE;
        wait_cyc(6);
        quiet;
        sp_ext <= sp_ext | 8'h01;
        wait_cyc(6);
        rd(ADDR_IRQ_STATUS, d);
        `CHK(d & 8'h02, 8'h02)
        wr(ADDR_OPTION_A, 8'hBF);
        quiet;
        sp_ext <= sp_ext & 8'hFE;
        wait_cyc(6);
        rd(ADDR_IRQ_STATUS, d);
        `CHK(d & 8'h02, 8'h02)
        quiet;
        sp_ext <= sp_ext | 8'h01;
        wait_cyc(6);
        rd(ADDR_IRQ_STATUS, d);
        `CHK(d & 8'h02, 8'h00)
        $display("t_ext done");
    endtask

    // Peripheral direction override and third-port data select
    task automatic t_ovr;
        // Direction written whole, never read-modify-write, while overrides act
        wr(ADDR_SECOND_DIR_A, 8'hFF);
        second_periph.ovr <= 8'h02;
        sp_en <= 8'hFD;
        wait_cyc(3);
        `CHK(second_pad.oe, 8'h02)
        second_periph.ovr_in <= 8'h02;
        sp_en <= 8'h02;
        wr(ADDR_SECOND_DIR_A, 8'h00);
        wait_cyc(3);
        `CHK(second_pad.oe, 8'hFD)
        wr(ADDR_THIRD_DIR, 8'hFF);
        third_periph.sel <= 8'h01;
        third_periph.dout <= 8'h01;
        third_periph.oe <= 8'h03;
        tp_en <= 8'hFC;
        wait_cyc(3);
        `CHK(third_pad.oe, 8'h01)
        `CHK(third_pad.out & 8'h01, 8'h01)
        $display("t_ovr done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        nrst = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 9'h000;
        reg_wdata = 8'h00;
        sp_ext = 8'h5A;
        sp_en = 8'hFF;
        tp_ext = 8'hC3;
        tp_en = 8'hFF;
        second_periph = '0;
        third_periph = '0;
        sleep_active = 1'b0;
        repeat (16) @(posedge clk_sys);
        nrst <= 1'b1;
        wait_cyc(2);
        t_reset;
        t_dir;
        t_pullup;
        t_change;
        t_ext;
        t_ovr;
        close_out;
    end
endmodule
